// ### uefm_pkg.sv
// Package of constants and types for the USB endpoint FIFO manager.
package uefm_pkg;

  // ----------------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------------
  localparam int SRAM_BYTES = 1024;
  localparam int ADDR_W     = 10;
  localparam int NUM_EP     = 6;
  localparam int EP_W       = 3;
  localparam int LEN_W      = 10;

  // ----------------------------------------------------------------------
  // Endpoint regions (byte base and size)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] EP0_BASE = 10'h000;
  localparam logic [ADDR_W-1:0] EP1_BASE = 10'h020;
  localparam logic [ADDR_W-1:0] EP2_BASE = 10'h040;
  localparam logic [ADDR_W-1:0] EP3_BASE = 10'h080;
  localparam logic [ADDR_W-1:0] EP4_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] EP5_BASE = 10'h200;
  localparam logic [LEN_W:0]    EP0_SIZE = 11'h020;
  localparam logic [LEN_W:0]    EP1_SIZE = 11'h020;
  localparam logic [LEN_W:0]    EP2_SIZE = 11'h040;
  localparam logic [LEN_W:0]    EP3_SIZE = 11'h080;
  localparam logic [LEN_W:0]    EP4_SIZE = 11'h100;
  localparam logic [LEN_W:0]    EP5_SIZE = 11'h200;

  // ----------------------------------------------------------------------
  // Reset value and FIFO depth and width
  // ----------------------------------------------------------------------
  localparam logic [LEN_W-1:0] SPLIT_RST = 10'h000;
  localparam int               FIFO_DEPTH = 4;
  localparam int               DATA_W     = 8;

  typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_INOUT} uefm_dir_t;
  typedef enum logic {TYPE_BULK_INT, TYPE_ISO} uefm_type_t;

endpackage

// ### uefm_fifo.sv
// Small valid/ready FIFO that buffers bytes on their way to the SRAM.
`timescale 1ns/10ps
module uefm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge clk_sys)
  begin
    if (doWr)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd)
      begin
        rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      if (doWr && !doRd)
      begin
        count <= count + 1'b1;
      end
      else if (doRd && !doWr)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### uefm_manager.sv
// Endpoint FIFO manager: region map, configuration and the endpoint SRAM.
`timescale 1ns/10ps
module uefm_manager #(
  parameter int DEPTH = uefm_pkg::FIFO_DEPTH
) (
  input  wire logic                         clk_sys,
  input  wire logic                         arst_n,
  // Endpoint configuration.
  input  wire logic [uefm_pkg::EP_W-1:0]    cfgEp,
  input  wire logic                         cfgWrite,
  input  wire uefm_pkg::uefm_type_t         cfgType,
  input  wire uefm_pkg::uefm_dir_t          cfgDir,
  input  wire logic                         cfgDouble,
  input  wire logic [uefm_pkg::LEN_W-1:0]   cfgSplit,
  output logic                              cfgError,
  // Link-side byte stream written into an endpoint.
  input  wire logic [uefm_pkg::EP_W-1:0]    linkEp,
  input  wire logic                         linkOut,
  input  wire logic                         linkBank,
  input  wire logic [uefm_pkg::LEN_W-1:0]   linkOffset,
  input  wire logic [7:0]                   linkData,
  input  wire logic                         linkValid,
  output logic                              linkReady,
  output logic                              linkOverrun,
  // Arbiter-side memory port.
  input  wire logic [uefm_pkg::ADDR_W-1:0]  memAddr,
  input  wire logic                         memRead,
  output logic [7:0]                        memRdata,
  output logic                              memRvalid,
  output logic                              memBusy
);
  import uefm_pkg::*;

  // ----------------------------------------------------------------------
  // Region map
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] epBase(input logic [EP_W-1:0] ep);
    case (ep)
      3'd0:    epBase = EP0_BASE;
      3'd1:    epBase = EP1_BASE;
      3'd2:    epBase = EP2_BASE;
      3'd3:    epBase = EP3_BASE;
      3'd4:    epBase = EP4_BASE;
      default: epBase = EP5_BASE;
    endcase
  endfunction

  function automatic logic [LEN_W:0] epSize(input logic [EP_W-1:0] ep);
    case (ep)
      3'd0:    epSize = EP0_SIZE;
      3'd1:    epSize = EP1_SIZE;
      3'd2:    epSize = EP2_SIZE;
      3'd3:    epSize = EP3_SIZE;
      3'd4:    epSize = EP4_SIZE;
      default: epSize = EP5_SIZE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Endpoint configuration
  // ----------------------------------------------------------------------
  uefm_type_t       epType   [NUM_EP];
  uefm_dir_t        epDir    [NUM_EP];
  logic             epDouble [NUM_EP];
  logic [LEN_W-1:0] epSplit  [NUM_EP];
  logic             cfgOk;

  // Endpoint 0 is fixed; 1-5 take type, direction and banking.
  assign cfgOk = (cfgEp != 3'd0) && (cfgEp < 3'(NUM_EP))
                 && (cfgDir != uefm_dir_t'(2'd3))
                 && ({1'b0, cfgSplit} <= epSize(cfgEp));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfgError <= 1'b0;
      for (int i = 0; i < NUM_EP; i++)
      begin
        epType[i]   <= TYPE_BULK_INT;
        epDir[i]    <= DIR_INOUT;
        epDouble[i] <= 1'b0;
        epSplit[i]  <= SPLIT_RST;
      end
    end
    else if (cfgWrite)
    begin
      cfgError <= !cfgOk;
      if (cfgOk)
      begin
        epType[cfgEp]   <= cfgType;
        epDir[cfgEp]    <= cfgDir;
        epDouble[cfgEp] <= cfgDouble;
        epSplit[cfgEp]  <= cfgSplit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link-side address computation
  // ----------------------------------------------------------------------
  // Within an INOUT region of endpoints 1-5, IN data sits below the split point and OUT above it.
  // A doubled direction is halved into two banks of equal size.
  logic [LEN_W:0]  dirLen;
  logic [LEN_W:0]  dirStart;
  logic [LEN_W:0]  bankLen;
  logic [LEN_W:0]  relAddr;
  logic            dirAllowed;
  logic            inRange;

  always_comb
  begin
    dirLen   = epSize(linkEp);
    dirStart = '0;
    if (epDir[linkEp] == DIR_INOUT && linkEp != 3'd0)
    begin
      if (linkOut)
      begin
        dirStart = {1'b0, epSplit[linkEp]};
        dirLen   = epSize(linkEp) - {1'b0, epSplit[linkEp]};
      end
      else
      begin
        dirLen = {1'b0, epSplit[linkEp]};
      end
    end
    bankLen = (epDouble[linkEp] && linkEp != 3'd0) ? (dirLen >> 1)
                                                   : dirLen;
    relAddr = dirStart + {1'b0, linkOffset}
              + ((linkBank && epDouble[linkEp]) ? bankLen : '0);
    dirAllowed = (linkEp == 3'd0) || (epDir[linkEp] == DIR_INOUT)
                 || (linkOut ? (epDir[linkEp] == DIR_OUT)
                             : (epDir[linkEp] == DIR_IN));
    // Bounds keep a write inside its own region.
    inRange = ({1'b0, linkOffset} < bankLen) && (linkEp < 3'(NUM_EP));
  end

  // ----------------------------------------------------------------------
  // Buffering of link bytes with their address
  // ----------------------------------------------------------------------
  logic [ADDR_W+7:0] fInData;
  logic [ADDR_W+7:0] fOutData;
  logic              fInValid;
  logic              fInReady;
  logic              fOutValid;
  logic              fOutReady;
  logic              accept;

  assign accept    = linkValid && dirAllowed && inRange;
  assign fInValid  = accept;
  assign fInData   = {epBase(linkEp) + relAddr[ADDR_W-1:0], linkData};
  // Illegal bytes are consumed and flagged so they never stall the link.
  assign linkReady = fInReady || !(dirAllowed && inRange);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkOverrun <= 1'b0;
    end
    else
    begin
      linkOverrun <= linkValid && !(dirAllowed && inRange);
    end
  end

  uefm_fifo #(
    .WIDTH (ADDR_W + 8),
    .DEPTH (DEPTH)
  ) uFifo (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .inData   (fInData),
    .inValid  (fInValid),
    .inReady  (fInReady),
    .outData  (fOutData),
    .outValid (fOutValid),
    .outReady (fOutReady)
  );

  // ----------------------------------------------------------------------
  // Endpoint SRAM with arbiter port
  // ----------------------------------------------------------------------
  // The arbiter read has priority; the FIFO absorbs the stall.
  logic [7:0] sram [SRAM_BYTES];

  assign fOutReady = !memRead;
  assign memBusy   = fOutValid && memRead;

  always_ff @(posedge clk_sys)
  begin
    if (fOutValid && fOutReady)
    begin
      sram[fOutData[ADDR_W+7:8]] <= fOutData[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memRdata  <= 8'h00;
      memRvalid <= 1'b0;
    end
    else
    begin
      memRvalid <= memRead;
      if (memRead)
      begin
        memRdata <= sram[memAddr];
      end
    end
  end

  // Packet timing toward the host lives in the serial engine; this
  // block only serves its full-speed byte stream.
endmodule

// ### uefm_checker.sv
// Concurrent checks on the ports of the endpoint FIFO manager.
`timescale 1ns/10ps
module uefm_checker (
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  input wire logic [2:0]           cfgEp,
  input wire logic                 cfgWrite,
  input wire uefm_pkg::uefm_dir_t  cfgDir,
  input wire logic [9:0]           cfgSplit,
  input wire logic                 cfgError,
  input wire logic [2:0]           linkEp,
  input wire logic [9:0]           linkOffset,
  input wire logic                 linkValid,
  input wire logic                 linkReady,
  input wire logic                 linkOverrun,
  input wire logic                 memRead,
  input wire logic                 memRvalid
);
  import uefm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence acc_s; linkValid && linkReady; endsequence
  sequence ep0_big_s; acc_s ##0 (linkEp == 0 && linkOffset >= 32); endsequence
  sequence ep3_big_s; acc_s ##0 (linkEp == 3 && linkOffset >= 128); endsequence
  cfg_hold_a: assert property (!cfgWrite |=> $stable(cfgError))
    else $error("config flag moved without a write");
  cfg_ep0_a: assert property (cfgWrite && cfgEp == 0 |=> cfgError)
    else $error("endpoint 0 config accepted");
  cfg_ephi_a: assert property (cfgWrite && cfgEp > 5 |=> cfgError)
    else $error("missing endpoint config accepted");
  cfg_dir_a: assert property (cfgWrite && cfgDir == 3 |=> cfgError)
    else $error("illegal direction accepted");
  cfg_split_a: assert property (
    cfgWrite && cfgEp == 1 && cfgSplit > 32 |=> cfgError)
    else $error("oversized split accepted");
  rd_answer_a: assert property (memRead |=> memRvalid)
    else $error("read not answered next cycle");
  rd_quiet_a: assert property (!memRead |=> !memRvalid)
    else $error("read data without a read");
  ovr_ep0_a: assert property (ep0_big_s |=> linkOverrun)
    else $error("endpoint 0 byte past its region kept");
  ovr_ep3_a: assert property (ep3_big_s |=> linkOverrun)
    else $error("endpoint 3 byte past its region kept");
  ovr_cause_a: assert property (
    $rose(linkOverrun) |-> $past(linkValid && linkReady))
    else $error("overrun without a byte");
endmodule

// ### uefm_host_model.sv
// Far-side model that pushes link bytes into the endpoints.
`timescale 1ns/10ps
module uefm_host_model (
  input wire logic clk_sys,
  output logic [2:0] linkEp,
  output logic       linkOut,
  output logic       linkBank,
  output logic [9:0] linkOffset,
  output logic [7:0] linkData,
  output logic       linkValid,
  input wire logic   linkReady
);
  initial
  begin
    {linkEp, linkOut, linkBank, linkOffset, linkData, linkValid} = '0;
  end
  // Held until an accepting edge, for at most 10 edges; data is scrambled once released.
  task automatic send(input logic [2:0] e, input logic o, input logic b,
                      input logic [9:0] f, input logic [7:0] d,
                      output logic ok);
    ok = 1'b0;
    @(negedge clk_sys);
    {linkEp, linkOut, linkBank, linkOffset, linkData} = {e, o, b, f, d};
    linkValid = 1'b1;
    for (int i = 0; i < 10 && !ok; i++)
    begin
      @(posedge clk_sys);
      ok = (linkReady === 1'b1);
    end
    @(negedge clk_sys);
    linkValid = 1'b0;
    linkData = ~linkData;
  endtask
endmodule

// ### tb_usb_endpoint_fifo_manager.sv
// Self-checking bench for the endpoint FIFO manager.
`timescale 1ns/10ps
module tb_usb_endpoint_fifo_manager;
  import uefm_pkg::*;
  logic       clk_sys = 0, arst_n = 0, cfgWrite = 0, cfgDouble = 0;
  logic       memRead = 0, linkOut, linkBank, linkValid, linkReady;
  logic       linkOverrun, cfgError, memRvalid, memBusy;
  logic [2:0] cfgEp = 0, linkEp;
  logic [9:0] cfgSplit = 0, linkOffset, memAddr = 0;
  logic [7:0] linkData, memRdata;
  uefm_type_t cfgType = TYPE_BULK_INT;
  uefm_dir_t  cfgDir = DIR_INOUT;
  int         miscompares = 0, checks_done = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  uefm_host_model host (.clk_sys(clk_sys), .linkEp(linkEp),
    .linkOut(linkOut), .linkBank(linkBank), .linkOffset(linkOffset),
    .linkData(linkData), .linkValid(linkValid), .linkReady(linkReady));
  uefm_manager uut (.clk_sys(clk_sys), .arst_n(arst_n), .cfgEp(cfgEp),
    .cfgWrite(cfgWrite), .cfgType(cfgType), .cfgDir(cfgDir),
    .cfgDouble(cfgDouble), .cfgSplit(cfgSplit), .cfgError(cfgError),
    .linkEp(linkEp), .linkOut(linkOut), .linkBank(linkBank),
    .linkOffset(linkOffset), .linkData(linkData), .linkValid(linkValid),
    .linkReady(linkReady), .linkOverrun(linkOverrun), .memAddr(memAddr),
    .memRead(memRead), .memRdata(memRdata), .memRvalid(memRvalid),
    .memBusy(memBusy));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cfg(input logic [2:0] e, input logic t, input logic [1:0] d,
                     input logic b, input logic [9:0] s, input logic err);
    @(negedge clk_sys);
    {cfgEp, cfgDouble, cfgSplit, cfgWrite} = {e, b, s, 1'b1};
    cfgType = uefm_type_t'(t);
    cfgDir = uefm_dir_t'(d);
    @(negedge clk_sys);
    cfgWrite = 1'b0;
    chk(cfgError, err);
  endtask
  // Sends one byte and checks the overrun pulse that follows it.
  task automatic wr(input logic [2:0] e, input logic o, input logic b,
                    input logic [9:0] f, input logic [7:0] d, input logic ov);
    logic ok;
    host.send(e, o, b, f, d, ok);
    chk({ok, linkOverrun}, {1'b1, ov});
    // A byte that is never taken means the link is stuck; stop here.
    if (!ok) report_and_stop;
  endtask
  // Reads until the drained byte shows, since writes pass through the FIFO.
  task automatic mchk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    d = ~e;
    for (int i = 0; i < 8 && d !== e; i++)
    begin
      @(negedge clk_sys);
      {memAddr, memRead} = {a, 1'b1};
      @(negedge clk_sys);
      memRead = 1'b0;
      d = memRdata;
      chk(memRvalid, 1'b1);
    end
    chk(d, e);
    if (d !== e) report_and_stop;
  endtask
  task automatic t_map;
    logic [9:0] base [6] = '{EP0_BASE, EP1_BASE, EP2_BASE, EP3_BASE,
                             EP4_BASE, EP5_BASE};
    logic [10:0] sz [6] = '{EP0_SIZE, EP1_SIZE, EP2_SIZE, EP3_SIZE,
                            EP4_SIZE, EP5_SIZE};
    chk({cfgError, linkOverrun, memRvalid}, 0);
    for (int e = 0; e < 6; e++)
    begin
      wr(e, 1, 0, 0, 8'h10 + e, 0);
      wr(e, 1, 0, sz[e][9:0] - 1, 8'h20 + e, 0);
      wr(e, 1, 0, sz[e][9:0], 8'h30 + e, 1);
    end
    for (int e = 0; e < 6; e++)
    begin
      mchk(base[e], 8'h10 + e);
      mchk(base[e] + sz[e][9:0] - 1, 8'h20 + e);
    end
    $display("t_map done");
  endtask
  task automatic t_cfg;
    cfg(0, 0, 1, 0, 0, 1);
    cfg(6, 0, 1, 0, 0, 1);
    cfg(2, 1, 3, 0, 0, 1);
    cfg(1, 0, 2, 0, 33, 1);
    for (int t = 0; t < 2; t++)
      for (int d = 0; d < 3; d++)
        cfg(5, t, d, 0, 0, 0);
    $display("t_cfg done");
  endtask
  task automatic t_split;
    cfg(4, 0, 2, 0, 16, 0);
    wr(4, 0, 0, 0, 8'hA1, 0);
    wr(4, 1, 0, 0, 8'hB2, 0);
    wr(4, 0, 0, 16, 8'hC3, 1);
    mchk(10'h100, 8'hA1);
    mchk(10'h110, 8'hB2);
    $display("t_split done");
  endtask
  task automatic t_double;
    cfg(3, 1, 1, 1, 0, 0);
    wr(3, 1, 1, 0, 8'h55, 0);
    wr(3, 1, 1, 64, 8'h56, 1);
    wr(3, 0, 0, 0, 8'h57, 1);
    wr(0, 1, 1, 0, 8'h66, 0);
    mchk(10'h0C0, 8'h55);
    mchk(10'h000, 8'h66);
    $display("t_double done");
  endtask
  // Reads held high keep the FIFO from draining until it refuses a byte.
  task automatic t_fill;
    logic ok;
    ok = 1'b1;
    @(negedge clk_sys);
    {memAddr, memRead} = {10'h3FF, 1'b1};
    for (int i = 0; i < 8 && ok; i++)
      host.send(2, 1, 0, i, 8'h80 + i, ok);
    chk(ok, 0);
    chk(memBusy, 1'b1);
    @(negedge clk_sys);
    memRead = 1'b0;
    mchk(10'h040, 8'h80);
    mchk(10'h041, 8'h81);
    $display("t_fill done");
  endtask
  // A reset in mid-run must clear the flags and the endpoint layout.
  task automatic t_reset;
    cfg(0, 0, 1, 0, 0, 1);
    @(negedge clk_sys);
    arst_n = 1'b0;
    @(negedge clk_sys);
    chk({cfgError, linkOverrun, memRvalid, memBusy}, 0);
    @(negedge clk_sys);
    arst_n = 1'b1;
    // Endpoint 3 was doubled OUT; after reset offset 100 must fit again.
    wr(3, 1, 1, 100, 8'h77, 0);
    mchk(10'h0E4, 8'h77);
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    t_map;
    t_cfg;
    t_split;
    t_double;
    t_fill;
    t_reset;
    report_and_stop;
  end
endmodule
bind uefm_manager uefm_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .cfgEp(cfgEp), .cfgWrite(cfgWrite), .cfgDir(cfgDir), .cfgSplit(cfgSplit),
  .cfgError(cfgError), .linkEp(linkEp), .linkOffset(linkOffset),
  .linkValid(linkValid), .linkReady(linkReady), .linkOverrun(linkOverrun),
  .memRead(memRead), .memRvalid(memRvalid));
